// file: hw/clock_gating_pkg.sv
// package: register map, field layout, unit indices and bus codes for the peripheral clock gating block
package clock_gating_pkg;

    // bus geometry
    localparam int ADDR_WIDTH = 12;
    localparam int DATA_WIDTH = 32;
    localparam int STRB_WIDTH = DATA_WIDTH / 8;

    // register byte offsets
    localparam logic [ADDR_WIDTH-1:0] RUN_MODE_GATE_CTRL_1_OFFSET   = 12'h104;
    localparam logic [ADDR_WIDTH-1:0] DEEP_SLEEP_GATE_CTRL_0_OFFSET = 12'h120;
    localparam logic [ADDR_WIDTH-1:0] GATE_MODE_CTRL_OFFSET         = 12'h140;
    localparam logic [ADDR_WIDTH-1:0] FAULT_STATUS_OFFSET           = 12'h144;
    localparam logic [ADDR_WIDTH-1:0] FAULT_MASK_OFFSET             = 12'h148;

    // reset values
    localparam logic [DATA_WIDTH-1:0] RUN_MODE_GATE_CTRL_1_RESET   = 32'h0000_0000;
    localparam logic [DATA_WIDTH-1:0] DEEP_SLEEP_GATE_CTRL_0_RESET = 32'h0000_0040;
    localparam logic [DATA_WIDTH-1:0] ZERO_WORD                    = 32'h0000_0000;

    // writable bit masks; every other bit is reserved, read-only zero
    localparam logic [DATA_WIDTH-1:0] RUN_MODE_GATE_CTRL_1_WMASK   = 32'h0000_5037;
    localparam logic [DATA_WIDTH-1:0] DEEP_SLEEP_GATE_CTRL_0_WMASK = 32'h0001_0F48;
    localparam logic [DATA_WIDTH-1:0] GATE_MODE_CTRL_WMASK         = 32'h0000_0001;

    // field positions in deep_sleep_gate_ctrl_0
    localparam int CONVERTER0_CLOCK_GATE_BIT  = 16;
    localparam int RATE_LSB                   = 8;
    localparam int RATE_WIDTH                 = 4;
    localparam int HIBERNATE_CLOCK_GATE_BIT   = 6;
    localparam int WATCHDOG_CLOCK_GATE_BIT    = 3;

    // field positions in run_mode_gate_ctrl_1
    localparam int TWOWIRE_UNIT1_CLOCK_GATE_BIT     = 14;
    localparam int TWOWIRE_UNIT0_CLOCK_GATE_BIT     = 12;
    localparam int SYNC_SERIAL_UNIT1_CLOCK_GATE_BIT = 5;
    localparam int SYNC_SERIAL_UNIT0_CLOCK_GATE_BIT = 4;
    localparam int ASYNC_SERIAL_UNIT2_CLOCK_GATE_BIT = 2;
    localparam int ASYNC_SERIAL_UNIT1_CLOCK_GATE_BIT = 1;
    localparam int ASYNC_SERIAL_UNIT0_CLOCK_GATE_BIT = 0;

    // field position in gate_mode_ctrl
    localparam int AUTO_CLOCK_GATE_SELECT_BIT = 0;

    // unit vector: one bit per gated unit
    localparam int UNIT_COUNT     = 10;
    localparam int UNIT_ASYNC0    = 0;
    localparam int UNIT_ASYNC1    = 1;
    localparam int UNIT_ASYNC2    = 2;
    localparam int UNIT_SYNC0     = 3;
    localparam int UNIT_SYNC1     = 4;
    localparam int UNIT_TWOWIRE0  = 5;
    localparam int UNIT_TWOWIRE1  = 6;
    localparam int UNIT_WATCHDOG  = 7;
    localparam int UNIT_HIBERNATE = 8;
    localparam int UNIT_CONVERTER = 9;
    // units whose unclocked access raises a bus fault (hibernate does not)
    localparam logic [UNIT_COUNT-1:0] FAULTING_UNITS = 10'h2FF;

    // converter sample rate codes
    localparam logic [RATE_WIDTH-1:0] RATE_1M   = 4'h3;
    localparam logic [RATE_WIDTH-1:0] RATE_500K = 4'h2;
    localparam logic [RATE_WIDTH-1:0] RATE_250K = 4'h1;
    localparam logic [RATE_WIDTH-1:0] RATE_125K = 4'h0;

    // bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // deep-sleep set of units held together
    typedef struct packed {
        logic                  converter0_clock_gate;
        logic [RATE_WIDTH-1:0] converter_max_sample_rate;
        logic                  hibernate_clock_gate;
        logic                  watchdog_clock_gate;
    } deep_sleep_set_type;

endpackage : clock_gating_pkg

// file: hw/peripheral_clock_gating.sv
// module: per-unit clock gating registers, enables and unclocked-access fault detection
//
// Function
// [R1] a set gate bit clocks its unit; a clear bit leaves it unclocked
// [R2] access to a unit whose clock is off answers with a bus fault
// [R3] gate bits come out of reset as zero unless noted otherwise
// [R4] deep-sleep set governs in deep-sleep, run set during normal running; converter_max_sample_rate follows bits 11:8 in normal running too
// [R5] sleep sets act only when the automatic gating select bit is set; converter_max_sample_rate always follows bits 11:8
// [R6] deep-sleep register bit 16 gates converter unit 0, read/write, resets zero
// [R7] rate field bits 11:8 selects 1M, 500K, 250K or 125K samples per second
// [R8] software must not program a rate above the converter maximum
// [R9] deep-sleep register bit 6 gates hibernation unit, no fault on access
// [R10] deep-sleep register bit 3 gates watchdog; unclocked watchdog access faults
// [R11] reserved bits are read-only zero; software preserves them
// [R12] run register 1 bits 14 and 12 gate two-wire units 1 and 0
// [R13] bits 5 and 4 gate synchronous serial units 1 and 0; 11:6, 3 reserved
// [R14] bits 2, 1, 0 gate asynchronous serial units 2, 1, 0
// [R15] deep-sleep register 0 resets to 0x00000040, hibernate gate set
// [R16] run register 1 resets to all zeros
// [R17] enable changes reach gated clocks glitch-free
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
module peripheral_clock_gating #(
    parameter int UNITS = clock_gating_pkg::UNIT_COUNT
) (
    input  wire logic                                     clk,
    input  wire logic                                     rst_b,
    // axi4-lite slave
    input  wire logic [clock_gating_pkg::ADDR_WIDTH-1:0]  s_axi_awaddr,
    input  wire logic                                     s_axi_awvalid,
    output logic                                          s_axi_awready,
    input  wire logic [clock_gating_pkg::DATA_WIDTH-1:0]  s_axi_wdata,
    input  wire logic [clock_gating_pkg::STRB_WIDTH-1:0]  s_axi_wstrb,
    input  wire logic                                     s_axi_wvalid,
    output logic                                          s_axi_wready,
    output logic [1:0]                                    s_axi_bresp,
    output logic                                          s_axi_bvalid,
    input  wire logic                                     s_axi_bready,
    input  wire logic [clock_gating_pkg::ADDR_WIDTH-1:0]  s_axi_araddr,
    input  wire logic                                     s_axi_arvalid,
    output logic                                          s_axi_arready,
    output logic [clock_gating_pkg::DATA_WIDTH-1:0]       s_axi_rdata,
    output logic [1:0]                                    s_axi_rresp,
    output logic                                          s_axi_rvalid,
    input  wire logic                                     s_axi_rready,
    // system power state and run-set enables of the units not held here
    input  wire logic                                     deep_sleep_active,
    input  wire logic [2:0]                               run_set0_enables,
    // accesses aimed at each unit, one-cycle pulse per access
    input  wire logic [UNITS-1:0]                         unit_access_req,
    // clock enables for the per-unit gating cells
    output logic [UNITS-1:0]                              unit_clock_en,
    output logic [clock_gating_pkg::RATE_WIDTH-1:0]       converter_max_sample_rate,
    output logic [UNITS-1:0]                              unit_bus_fault,
    output logic                                          irq
);

    // register state
    logic [clock_gating_pkg::DATA_WIDTH-1:0] run_gate_ctrl_1_q;
    logic [clock_gating_pkg::DATA_WIDTH-1:0] deep_sleep_gate_ctrl_0_q;
    logic                                    auto_clock_gate_select_q;
    logic [UNITS-1:0]                        fault_status_q;
    logic [UNITS-1:0]                        fault_mask_q;

    // bus handshake state
    logic                                    awready_q;
    logic                                    wready_q;
    logic                                    bvalid_q;
    logic [1:0]                              bresp_q;
    logic                                    arready_q;
    logic                                    rvalid_q;
    logic [1:0]                              rresp_q;
    logic [clock_gating_pkg::DATA_WIDTH-1:0] rdata_q;
    logic [clock_gating_pkg::ADDR_WIDTH-1:0] waddr_q;
    logic [clock_gating_pkg::DATA_WIDTH-1:0] wdata_q;
    logic [clock_gating_pkg::STRB_WIDTH-1:0] wstrb_q;

    // output flops
    logic [UNITS-1:0]                          unit_clock_en_q;
    logic [clock_gating_pkg::RATE_WIDTH-1:0]   rate_q;
    logic [UNITS-1:0]                          unit_bus_fault_q;
    logic                                      irq_q;

    // combinational helpers
    logic                                      aw_take;
    logic                                      w_take;
    logic                                      ar_take;
    logic                                      write_fire;
    logic                                      write_hit;
    logic [clock_gating_pkg::DATA_WIDTH-1:0]   write_bits;
    logic [clock_gating_pkg::DATA_WIDTH-1:0]   read_word;
    logic                                      read_hit;
    logic [UNITS-1:0]                          unit_clock_en_d;
    logic [UNITS-1:0]                          fault_event;
    logic [UNITS-1:0]                          status_clear;
    clock_gating_pkg::deep_sleep_set_type      ds_set;

    // expand byte strobes into a bit mask
    function automatic logic [clock_gating_pkg::DATA_WIDTH-1:0] strobe_bits(
        input logic [clock_gating_pkg::STRB_WIDTH-1:0] strb
    );
        logic [clock_gating_pkg::DATA_WIDTH-1:0] bits;
        bits = clock_gating_pkg::ZERO_WORD;
        for (int b = 0; b < clock_gating_pkg::STRB_WIDTH; b++) begin
            bits[b*8 +: 8] = {8{strb[b]}};
        end
        return bits;
    endfunction : strobe_bits

    // handshakes; a write fires once address and data are both held
    assign aw_take    = s_axi_awvalid & awready_q;
    assign w_take     = s_axi_wvalid & wready_q;
    assign ar_take    = s_axi_arvalid & arready_q;
    assign write_fire = ~awready_q & ~wready_q & ~bvalid_q;
    assign write_bits = strobe_bits(wstrb_q);

    // address decode of the held write
    always_comb begin
        unique case (waddr_q)
            clock_gating_pkg::RUN_MODE_GATE_CTRL_1_OFFSET,
            clock_gating_pkg::DEEP_SLEEP_GATE_CTRL_0_OFFSET,
            clock_gating_pkg::GATE_MODE_CTRL_OFFSET,
            clock_gating_pkg::FAULT_STATUS_OFFSET,
            clock_gating_pkg::FAULT_MASK_OFFSET: write_hit = 1'b1;
            default:                             write_hit = 1'b0;
        endcase
    end

    // write address channel
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            awready_q <= 1'b1;
            waddr_q   <= '0;
        end else if (aw_take) begin
            awready_q <= 1'b0;
            waddr_q   <= s_axi_awaddr;
        end else if (bvalid_q && s_axi_bready) begin
            awready_q <= 1'b1;
        end
    end

    // write data channel
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wready_q <= 1'b1;
            wdata_q  <= clock_gating_pkg::ZERO_WORD;
            wstrb_q  <= '0;
        end else if (w_take) begin
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (bvalid_q && s_axi_bready) begin
            wready_q <= 1'b1;
        end
    end

    // write response
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bvalid_q <= 1'b0;
            bresp_q  <= clock_gating_pkg::RESP_OKAY;
        end else if (write_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= write_hit ? clock_gating_pkg::RESP_OKAY : clock_gating_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // run-mode gate register 1: serial units, reserved bits stay zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_gate_ctrl_1_q <= clock_gating_pkg::RUN_MODE_GATE_CTRL_1_RESET; // see [R3] see [R16]
        end else if (write_fire && waddr_q == clock_gating_pkg::RUN_MODE_GATE_CTRL_1_OFFSET) begin
            run_gate_ctrl_1_q <= ((run_gate_ctrl_1_q & ~write_bits) | (wdata_q & write_bits))
                                 & clock_gating_pkg::RUN_MODE_GATE_CTRL_1_WMASK; // see [R11] see [R13]
        end
    end

    // deep-sleep gate register 0: converter, rate field, hibernate, watchdog
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            deep_sleep_gate_ctrl_0_q <= clock_gating_pkg::DEEP_SLEEP_GATE_CTRL_0_RESET; // see [R15]
        end else if (write_fire && waddr_q == clock_gating_pkg::DEEP_SLEEP_GATE_CTRL_0_OFFSET) begin
            deep_sleep_gate_ctrl_0_q <= ((deep_sleep_gate_ctrl_0_q & ~write_bits) | (wdata_q & write_bits))
                                        & clock_gating_pkg::DEEP_SLEEP_GATE_CTRL_0_WMASK; // see [R11]
        end
    end

    // automatic gating select
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            auto_clock_gate_select_q <= 1'b0;
        end else if (write_fire && waddr_q == clock_gating_pkg::GATE_MODE_CTRL_OFFSET
                     && wstrb_q[0]) begin
            auto_clock_gate_select_q <= wdata_q[clock_gating_pkg::AUTO_CLOCK_GATE_SELECT_BIT];
        end
    end

    // fault mask
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fault_mask_q <= '0;
        end else if (write_fire && waddr_q == clock_gating_pkg::FAULT_MASK_OFFSET) begin
            fault_mask_q <= (fault_mask_q & ~write_bits[UNITS-1:0]) | (wdata_q[UNITS-1:0] & write_bits[UNITS-1:0]);
        end
    end

    // deep-sleep set fields
    assign ds_set.converter0_clock_gate     = deep_sleep_gate_ctrl_0_q[clock_gating_pkg::CONVERTER0_CLOCK_GATE_BIT];
    assign ds_set.converter_max_sample_rate =
        deep_sleep_gate_ctrl_0_q[clock_gating_pkg::RATE_LSB +: clock_gating_pkg::RATE_WIDTH];
    assign ds_set.hibernate_clock_gate      = deep_sleep_gate_ctrl_0_q[clock_gating_pkg::HIBERNATE_CLOCK_GATE_BIT];
    assign ds_set.watchdog_clock_gate       = deep_sleep_gate_ctrl_0_q[clock_gating_pkg::WATCHDOG_CLOCK_GATE_BIT];

    // pick the governing set per unit: deep-sleep set only with auto gating in deep-sleep
    always_comb begin
        unit_clock_en_d = '0;
        unit_clock_en_d[clock_gating_pkg::UNIT_ASYNC0] =
            run_gate_ctrl_1_q[clock_gating_pkg::ASYNC_SERIAL_UNIT0_CLOCK_GATE_BIT]; // see [R14]
        unit_clock_en_d[clock_gating_pkg::UNIT_ASYNC1] =
            run_gate_ctrl_1_q[clock_gating_pkg::ASYNC_SERIAL_UNIT1_CLOCK_GATE_BIT]; // see [R14]
        unit_clock_en_d[clock_gating_pkg::UNIT_ASYNC2] =
            run_gate_ctrl_1_q[clock_gating_pkg::ASYNC_SERIAL_UNIT2_CLOCK_GATE_BIT]; // see [R14]
        unit_clock_en_d[clock_gating_pkg::UNIT_SYNC0] =
            run_gate_ctrl_1_q[clock_gating_pkg::SYNC_SERIAL_UNIT0_CLOCK_GATE_BIT]; // see [R13]
        unit_clock_en_d[clock_gating_pkg::UNIT_SYNC1] =
            run_gate_ctrl_1_q[clock_gating_pkg::SYNC_SERIAL_UNIT1_CLOCK_GATE_BIT]; // see [R13]
        unit_clock_en_d[clock_gating_pkg::UNIT_TWOWIRE0] =
            run_gate_ctrl_1_q[clock_gating_pkg::TWOWIRE_UNIT0_CLOCK_GATE_BIT]; // see [R12]
        unit_clock_en_d[clock_gating_pkg::UNIT_TWOWIRE1] =
            run_gate_ctrl_1_q[clock_gating_pkg::TWOWIRE_UNIT1_CLOCK_GATE_BIT]; // see [R12]
        if (auto_clock_gate_select_q && deep_sleep_active) begin // see [R4] see [R5]
            unit_clock_en_d[clock_gating_pkg::UNIT_WATCHDOG]  = ds_set.watchdog_clock_gate;   // see [R10]
            unit_clock_en_d[clock_gating_pkg::UNIT_HIBERNATE] = ds_set.hibernate_clock_gate;  // see [R9]
            unit_clock_en_d[clock_gating_pkg::UNIT_CONVERTER] = ds_set.converter0_clock_gate; // see [R6]
        end else begin
            unit_clock_en_d[clock_gating_pkg::UNIT_WATCHDOG]  = run_set0_enables[0];
            unit_clock_en_d[clock_gating_pkg::UNIT_HIBERNATE] = run_set0_enables[1];
            unit_clock_en_d[clock_gating_pkg::UNIT_CONVERTER] = run_set0_enables[2];
        end
    end

    // enables change only at a clock edge, so a latch-based gating cell never sees a glitch
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            unit_clock_en_q <= '0; // see [R3]
        end else begin
            unit_clock_en_q <= unit_clock_en_d; // see [R1] see [R17]
        end
    end

    // converter rate, passed as programmed; software keeps it within the converter maximum
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rate_q <= clock_gating_pkg::RATE_125K;
        end else begin
            rate_q <= ds_set.converter_max_sample_rate; // see [R7] see [R8]
        end
    end

    // fault detection per unit: an access to an unclocked faulting unit
    for (genvar u = 0; u < UNITS; u++) begin : g_fault
        assign fault_event[u]  = unit_access_req[u] & ~unit_clock_en_q[u]
                                 & clock_gating_pkg::FAULTING_UNITS[u]; // see [R2] see [R9] see [R10]
        assign status_clear[u] = write_fire && waddr_q == clock_gating_pkg::FAULT_STATUS_OFFSET
                                 && write_bits[u] && wdata_q[u];

        // bus fault answer to the accessing master
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                unit_bus_fault_q[u] <= 1'b0;
            end else begin
                unit_bus_fault_q[u] <= fault_event[u]; // see [R2]
            end
        end

        // sticky status, write one to clear, a new fault wins over the clear
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                fault_status_q[u] <= 1'b0;
            end else if (fault_event[u]) begin
                fault_status_q[u] <= 1'b1;
            end else if (status_clear[u]) begin
                fault_status_q[u] <= 1'b0;
            end
        end
    end

    // interrupt level from unmasked status
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(fault_status_q & fault_mask_q);
        end
    end

    // read mux; unmapped addresses answer slverr with zero data
    always_comb begin
        read_word = clock_gating_pkg::ZERO_WORD;
        read_hit  = 1'b1;
        unique case (s_axi_araddr)
            clock_gating_pkg::RUN_MODE_GATE_CTRL_1_OFFSET:   read_word = run_gate_ctrl_1_q;
            clock_gating_pkg::DEEP_SLEEP_GATE_CTRL_0_OFFSET: read_word = deep_sleep_gate_ctrl_0_q;
            clock_gating_pkg::GATE_MODE_CTRL_OFFSET:
                read_word[clock_gating_pkg::AUTO_CLOCK_GATE_SELECT_BIT] = auto_clock_gate_select_q;
            clock_gating_pkg::FAULT_STATUS_OFFSET:           read_word[UNITS-1:0] = fault_status_q;
            clock_gating_pkg::FAULT_MASK_OFFSET:             read_word[UNITS-1:0] = fault_mask_q;
            default:                                         read_hit = 1'b0;
        endcase
    end

    // read channel: one read in flight
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= clock_gating_pkg::RESP_OKAY;
            rdata_q   <= clock_gating_pkg::ZERO_WORD;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= read_hit ? clock_gating_pkg::RESP_OKAY : clock_gating_pkg::RESP_SLVERR;
            rdata_q   <= read_word; // see [R11]
        end else if (rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // outputs straight from flops
    assign s_axi_awready             = awready_q;
    assign s_axi_wready              = wready_q;
    assign s_axi_bvalid              = bvalid_q;
    assign s_axi_bresp               = bresp_q;
    assign s_axi_arready             = arready_q;
    assign s_axi_rvalid              = rvalid_q;
    assign s_axi_rresp               = rresp_q;
    assign s_axi_rdata               = rdata_q;
    assign unit_clock_en             = unit_clock_en_q;
    assign converter_max_sample_rate = rate_q;
    assign unit_bus_fault            = unit_bus_fault_q;
    assign irq                       = irq_q;

endmodule : peripheral_clock_gating

// file: dv/gating_checker_sva.sv
// checker: port-level properties of the peripheral clock gating block
`timescale 1ns/1ns
module gating_checker #(
    parameter int UNITS = 10
) (
    input wire logic             clk,
    input wire logic             rst_b,
    input wire logic             s_axi_bvalid,
    input wire logic [UNITS-1:0] unit_access_req,
    input wire logic [UNITS-1:0] unit_clock_en,
    input wire logic [UNITS-1:0] unit_bus_fault
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // fault behaviour per access, and enables out of reset
    property p_fault_off; unit_access_req[0] && !unit_clock_en[0] |=> unit_bus_fault[0]; endproperty
    a_fault_off: assert property (p_fault_off) else $error("no fault on unclocked access");
    property p_fault_on; unit_access_req[6] && unit_clock_en[6] |=> !unit_bus_fault[6]; endproperty
    a_fault_on: assert property (p_fault_on) else $error("fault on clocked access");
    property p_wdt; unit_access_req[7] && !unit_clock_en[7] |=> unit_bus_fault[7]; endproperty
    a_wdt: assert property (p_wdt) else $error("no fault on unclocked watchdog");
    property p_hib; !unit_bus_fault[8]; endproperty
    a_hib: assert property (p_hib) else $error("hibernate access faulted");
    property p_cause; (unit_bus_fault & ~$past(unit_access_req)) == '0; endproperty
    a_cause: assert property (p_cause) else $error("fault without access");
    property p_pulse; unit_bus_fault[0] && !unit_access_req[0] |=> !unit_bus_fault[0]; endproperty
    a_pulse: assert property (p_pulse) else $error("fault longer than one cycle");
    property p_reset; $rose(rst_b) |-> unit_clock_en == '0; endproperty
    a_reset: assert property (p_reset) else $error("unit clocked out of reset");
    // serial enables move only after a completed write
    property p_serial; $changed(unit_clock_en[6:0]) |-> $past(s_axi_bvalid); endproperty
    a_serial: assert property (p_serial) else $error("serial enable changed without write");
endmodule : gating_checker
bind peripheral_clock_gating gating_checker #(.UNITS(UNITS)) gating_checker_i (.clk(clk), .rst_b(rst_b),
    .s_axi_bvalid(s_axi_bvalid), .unit_access_req(unit_access_req), .unit_clock_en(unit_clock_en),
    .unit_bus_fault(unit_bus_fault));

// file: dv/peripheral_clock_gating_tb.sv
// testbench: register access, gating enables, mode select and fault checks
`timescale 1ns/1ns
module peripheral_clock_gating_tb;
    logic        clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, deep, irq;
    logic [1:0]  bresp, rresp;
    logic [2:0]  run_en;
    logic [3:0]  rate;
    logic [9:0]  req, en, fault;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    int          mismatches = 0;
    int          checked = 0;
    int          cyc = 0;
    int          pos[7] = '{0, 1, 2, 4, 5, 12, 14};

    peripheral_clock_gating peripheral_clock_gating_i (.clk(clk), .rst_b(rst_b),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .deep_sleep_active(deep), .run_set0_enables(run_en), .unit_access_req(req),
        .unit_clock_en(en), .converter_max_sample_rate(rate), .unit_bus_fault(fault), .irq(irq));

    // clock and hang guard
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // axi4-lite write, holds each channel until taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask : wr

    // axi4-lite read with expected data and response
    task automatic rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
    endtask : rdc

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic summarize;
        if (mismatches == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    // main sequence
    initial begin
        {clk, rst_b, awvalid, wvalid, bready, arvalid, rready, deep} = '0;
        {run_en, req, awaddr, araddr, wdata} = '0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        chk(32'(en), 32'h0);
        rdc(clock_gating_pkg::RUN_MODE_GATE_CTRL_1_OFFSET, 32'h0000_0000, 2'h0);
        rdc(clock_gating_pkg::DEEP_SLEEP_GATE_CTRL_0_OFFSET, 32'h0000_0040, 2'h0);
        wr(clock_gating_pkg::RUN_MODE_GATE_CTRL_1_OFFSET, 32'hFFFF_FFFF, 2'h0);
        rdc(clock_gating_pkg::RUN_MODE_GATE_CTRL_1_OFFSET, 32'h0000_5037, 2'h0);
        foreach (pos[i]) begin
            wr(clock_gating_pkg::RUN_MODE_GATE_CTRL_1_OFFSET, 32'h1 << pos[i], 2'h0);
            settle();
            chk(32'(en), 32'h1 << i);
        end
        wr(clock_gating_pkg::DEEP_SLEEP_GATE_CTRL_0_OFFSET, 32'hFFFF_FFFF, 2'h0);
        rdc(clock_gating_pkg::DEEP_SLEEP_GATE_CTRL_0_OFFSET, 32'h0001_0F48, 2'h0);
        // only the four documented rate codes are programmed, never above the maximum
        for (int r = 0; r < 4; r++) begin
            wr(clock_gating_pkg::DEEP_SLEEP_GATE_CTRL_0_OFFSET, 32'h0001_0048 | (r << 8), 2'h0);
            settle();
            chk(32'(rate), r);
        end
        @(posedge clk);
        deep <= 1'b1;
        settle();
        chk(32'(en[9:7]), 32'h0);
        wr(clock_gating_pkg::GATE_MODE_CTRL_OFFSET, 32'h1, 2'h0);
        settle();
        chk(32'(en[9:7]), 32'h7);
        @(posedge clk);
        deep <= 1'b0;
        run_en <= 3'h5;
        settle();
        chk(32'(en[9:7]), 32'h5);
        @(posedge clk);
        run_en <= 3'h0;
        settle();
        @(posedge clk);
        req <= 10'h3FF;
        @(posedge clk);
        req <= 10'h000;
        #1;
        chk(32'(fault), 32'h0000_02BF);
        rdc(clock_gating_pkg::FAULT_STATUS_OFFSET, 32'h0000_02BF, 2'h0);
        chk(32'(irq), 32'h0);
        wr(clock_gating_pkg::FAULT_MASK_OFFSET, 32'h0000_03FF, 2'h0);
        settle();
        chk(32'(irq), 32'h1);
        wr(clock_gating_pkg::FAULT_STATUS_OFFSET, 32'h0000_02BF, 2'h0);
        settle();
        chk(32'(irq), 32'h0);
        rdc(12'h200, 32'h0, 2'h2);
        wr(12'h200, 32'hFFFF_FFFF, 2'h2);
        summarize();
    end
endmodule : peripheral_clock_gating_tb
